// *** design/sor_pkg.sv ***
// Behaviour
// - Watermark flag is 1 when fill count is at or above the watermark.
// - Overrun flag sets only when the queue is full and a sample was overwritten.
// - Six-bit fill count: 0 means empty, 32 means full.
// - After an overwrite the status reads watermark 1, overrun 1, count 32.
// - Temperature overrun sets when a new result replaces an unread one.
// - Pressure overrun sets when a new result replaces an unread one.
// - Temperature-ready flag is 1 while an unread temperature result exists.
// - Pressure-ready flag is 1 from a queue push until the next read of byte 2Ah, even if samples remain.
// - The sample flags register is refreshed once per output-data-rate period.
// - Pressure is 24-bit two's complement in bytes 28h, 29h, 2Ah.
// - With differential and auto features off, pressure is measured minus offset.
// - The 16-bit offset is scaled by 256 before subtraction.
// - Temperature is 16-bit two's complement in bytes 2Bh and 2Ch.
// - Reading the filter clear register resets the pressure smoothing filter.
// - The watermark is the five-bit field in bits 4:0 of the queue control.
package sor_pkg;
    localparam logic [7:0] ADDR_QUEUE_CTRL   = 8'h14;
    localparam logic [7:0] ADDR_TRIM_LOW     = 8'h18;
    localparam logic [7:0] ADDR_TRIM_HIGH    = 8'h19;
    localparam logic [7:0] ADDR_FILL_STATE   = 8'h26;
    localparam logic [7:0] ADDR_SAMPLE_FLAGS = 8'h27;
    localparam logic [7:0] ADDR_PRESS_LOW    = 8'h28;
    localparam logic [7:0] ADDR_PRESS_MID    = 8'h29;
    localparam logic [7:0] ADDR_PRESS_HIGH   = 8'h2a;
    localparam logic [7:0] ADDR_TEMP_LOW     = 8'h2b;
    localparam logic [7:0] ADDR_TEMP_HIGH    = 8'h2c;
    localparam logic [7:0] ADDR_FILTER_CLEAR = 8'h33;

    localparam int PRESS_W    = 24;
    localparam int TEMP_W     = 16;
    localparam int TRIM_W     = 16;
    localparam int TRIM_SHIFT = 8;
    localparam int QUEUE_DEPTH = 32;
    localparam int FILL_W     = 6;
    localparam int WTM_W      = 5;
    localparam int CTRL_MODE_W = 3;

    localparam int FILL_WMARK_BIT = 7;
    localparam int FILL_OVR_BIT   = 6;
    localparam int FLAG_T_OR_BIT  = 5;
    localparam int FLAG_P_OR_BIT  = 4;
    localparam int FLAG_T_DA_BIT  = 1;
    localparam int FLAG_P_DA_BIT  = 0;

    localparam logic [7:0]        BYTE_ZERO  = 8'h00;
    localparam logic [WTM_W-1:0]  WTM_RESET  = 5'h00;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 16'h0000;

    typedef logic [7:0] sor_byte_type;
    typedef enum logic [1:0] {
        BYTE_LOW  = 2'b00,
        BYTE_MID  = 2'b01,
        BYTE_HIGH = 2'b10
    } sor_lane_type;

    function automatic sor_byte_type sor_byte_sel(input logic [PRESS_W-1:0] v,
                                                  input sor_lane_type lane);
        sor_byte_type b;
        b = BYTE_ZERO;
        unique case (lane)
            BYTE_LOW:  b = v[7:0];
            BYTE_MID:  b = v[15:8];
            BYTE_HIGH: b = v[23:16];
            default:   b = BYTE_ZERO;
        endcase
        return b;
    endfunction : sor_byte_sel
endpackage : sor_pkg

// *** design/sor_stream_if.sv ***
`timescale 1ns/1ps
interface sor_stream_if #(parameter int WIDTH = 24) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport producer (output valid, output data, input ready);
    modport consumer (input valid, input data, output ready);
endinterface : sor_stream_if

// *** design/sor_pair_buf.sv ***
`timescale 1ns/1ps
module sor_pair_buf #(
    parameter int WIDTH = 24
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    sor_stream_if.consumer     in_s,
    sor_stream_if.producer     out_s
);
    import sor_pkg::*;

    logic [WIDTH-1:0] d0_r;
    logic [WIDTH-1:0] d1_r;
    logic [1:0]       cnt_r;
    logic [1:0]       cnt_nxt;
    logic             ready_r;
    logic             in_fire;
    logic             out_fire;

    assign in_fire     = in_s.valid & ready_r;
    assign out_fire    = (cnt_r != 2'h0) & out_s.ready;
    assign in_s.ready  = ready_r;
    assign out_s.valid = (cnt_r != 2'h0);
    assign out_s.data  = d0_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (in_fire && !out_fire) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (!in_fire && out_fire) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r   <= 2'h0;
            ready_r <= 1'b1;
        end else begin
            cnt_r   <= cnt_nxt;
            ready_r <= (cnt_nxt != 2'h2);
        end
    end

    // Entry 0 is always the head, so the drain side sees a flop output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            d0_r <= '0;
            d1_r <= '0;
        end else if (out_fire) begin
            d0_r <= (cnt_r == 2'h2) ? d1_r : in_s.data;
            if (in_fire && cnt_r == 2'h2) begin
                d1_r <= in_s.data;
            end
        end else if (in_fire) begin
            if (cnt_r == 2'h0) begin
                d0_r <= in_s.data;
            end else begin
                d1_r <= in_s.data;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_buf_no_loss: assert property (cnt_r == 2'h2 |-> !ready_r)
        else $error("pair buffer accepts while full");
endmodule : sor_pair_buf

// *** design/sor_sample_mem.sv ***
`timescale 1ns/1ps
module sor_sample_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Array has no reset so it can map onto plain RAM
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : sor_sample_mem

// *** design/sor_output_regs.sv ***
`timescale 1ns/1ps
module sor_output_regs #(
    parameter int DEPTH = 32
) (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_rd,
    input  wire logic                      reg_wr,
    input  wire logic [7:0]                reg_wdata,
    output logic      [7:0]                reg_rdata,
    output logic                           reg_rvalid,
    input  wire logic                      press_valid,
    input  wire logic [sor_pkg::PRESS_W-1:0] press_meas,
    output logic                           press_ready,
    input  wire logic                      temp_valid,
    input  wire logic [sor_pkg::TEMP_W-1:0]  temp_meas,
    input  wire logic                      odr_tick,
    input  wire logic                      differential_select,
    input  wire logic                      autozero_select,
    input  wire logic                      auto_reference_hold,
    output logic                           filter_clear
);
    import sor_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(DEPTH);

    logic [CTRL_MODE_W-1:0] ctrl_mode_r;
    logic [WTM_W-1:0]       queue_watermark_level_r;
    logic [TRIM_W-1:0]      pressure_offset_trim_r;
    logic [FILL_W-1:0]      queue_fill_count_r;
    logic [FILL_W-1:0]      fill_nxt;
    logic                   queue_overwrite_flag_r;
    logic [AW-1:0]          wr_ptr_r;
    logic [AW-1:0]          rd_ptr_r;
    logic [PRESS_W-1:0]     head_data;
    logic [PRESS_W-1:0]     trimmed;
    logic [TEMP_W-1:0]      temperature_result_r;
    logic [15:0]            p_shadow_r;
    logic [7:0]             t_shadow_r;
    logic                   p_lock_r;
    logic                   t_lock_r;
    logic                   p_new_r;
    logic                   t_new_r;
    logic                   p_or_r;
    logic                   t_or_r;
    logic [7:0]             sample_flags_r;
    logic [7:0]             rdata_nxt;
    logic                   queue_watermark_flag;
    logic                   full;
    logic                   push;
    logic                   pop;
    logic                   overwrite;
    logic                   rd_p_low;
    logic                   rd_p_high;
    logic                   rd_t_low;
    logic                   rd_t_high;

    sor_stream_if #(.WIDTH(PRESS_W)) press_in_s ();
    sor_stream_if #(.WIDTH(PRESS_W)) press_q_s ();

    assign rd_p_low  = reg_rd && reg_addr == ADDR_PRESS_LOW;
    assign rd_p_high = reg_rd && reg_addr == ADDR_PRESS_HIGH;
    assign rd_t_low  = reg_rd && reg_addr == ADDR_TEMP_LOW;
    assign rd_t_high = reg_rd && reg_addr == ADDR_TEMP_HIGH;

    // Other pressure modes belong to another block; raw value passes there
    always_comb begin
        trimmed = press_meas;
        if (!differential_select && !autozero_select && !auto_reference_hold) begin
            trimmed = press_meas - {pressure_offset_trim_r, TRIM_SHIFT'(0)};
        end
    end

    assign press_in_s.valid = press_valid;
    assign press_in_s.data  = trimmed;
    assign press_ready      = press_in_s.ready;
    // A half-read sample must not be overwritten, so the buffer soaks it up
    assign press_q_s.ready  = !p_lock_r;

    sor_pair_buf #(.WIDTH(PRESS_W)) u_pair_buf (
        .clk    (clk),
        .resetn (resetn),
        .in_s   (press_in_s.consumer),
        .out_s  (press_q_s.producer)
    );

    sor_sample_mem #(.WIDTH(PRESS_W), .DEPTH(DEPTH), .AW(AW)) u_sample_mem (
        .clk     (clk),
        .resetn  (resetn),
        .wr_en   (push),
        .wr_addr (wr_ptr_r),
        .wr_data (press_q_s.data),
        .rd_addr (rd_ptr_r),
        .rd_data (head_data)
    );

    assign full      = queue_fill_count_r == FILL_FULL;
    assign push      = press_q_s.valid && press_q_s.ready;
    assign pop       = rd_p_high && queue_fill_count_r != '0;
    assign overwrite = push && !pop && full;
    assign queue_watermark_flag =
        queue_fill_count_r >= FILL_W'(queue_watermark_level_r);

    always_comb begin
        fill_nxt = queue_fill_count_r;
        if (push && !pop && !full) begin
            fill_nxt = queue_fill_count_r + FILL_W'(1);
        end else if (pop && !push) begin
            fill_nxt = queue_fill_count_r - FILL_W'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_mode_r             <= '0;
            queue_watermark_level_r <= WTM_RESET;
            pressure_offset_trim_r  <= TRIM_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_QUEUE_CTRL) begin
                ctrl_mode_r             <= reg_wdata[7:WTM_W];
                queue_watermark_level_r <= reg_wdata[WTM_W-1:0];
            end
            if (reg_addr == ADDR_TRIM_LOW) begin
                pressure_offset_trim_r[7:0] <= reg_wdata;
            end
            if (reg_addr == ADDR_TRIM_HIGH) begin
                pressure_offset_trim_r[15:8] <= reg_wdata;
            end
        end
    end

    // Pointers wrap by width, so the depth must stay a power of two
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r           <= '0;
            rd_ptr_r           <= '0;
            queue_fill_count_r <= '0;
        end else begin
            queue_fill_count_r <= fill_nxt;
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop || overwrite) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            queue_overwrite_flag_r <= 1'b0;
        end else if (overwrite) begin
            queue_overwrite_flag_r <= 1'b1;
        end else if (pop) begin
            queue_overwrite_flag_r <= 1'b0;
        end
    end

    // Set wins over the read that clears
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p_new_r <= 1'b0;
            p_or_r  <= 1'b0;
        end else begin
            if (push) begin
                p_new_r <= 1'b1;
            end else if (rd_p_high) begin
                p_new_r <= 1'b0;
            end
            if (push && p_new_r) begin
                p_or_r <= 1'b1;
            end else if (rd_p_high) begin
                p_or_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temperature_result_r <= '0;
            t_new_r              <= 1'b0;
            t_or_r               <= 1'b0;
        end else begin
            if (temp_valid) begin
                temperature_result_r <= temp_meas;
                t_new_r              <= 1'b1;
            end else if (rd_t_high) begin
                t_new_r <= 1'b0;
            end
            if (temp_valid && t_new_r) begin
                t_or_r <= 1'b1;
            end else if (rd_t_high) begin
                t_or_r <= 1'b0;
            end
        end
    end

    // Low byte read freezes the upper bytes until the high byte is read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p_lock_r   <= 1'b0;
            p_shadow_r <= '0;
            t_lock_r   <= 1'b0;
            t_shadow_r <= '0;
        end else begin
            if (rd_p_low) begin
                p_lock_r   <= 1'b1;
                p_shadow_r <= head_data[23:8];
            end else if (rd_p_high) begin
                p_lock_r <= 1'b0;
            end
            if (rd_t_low) begin
                t_lock_r   <= 1'b1;
                t_shadow_r <= temperature_result_r[15:8];
            end else if (rd_t_high) begin
                t_lock_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_flags_r <= BYTE_ZERO;
        end else if (odr_tick) begin
            sample_flags_r                <= BYTE_ZERO;
            sample_flags_r[FLAG_T_OR_BIT] <= t_or_r;
            sample_flags_r[FLAG_P_OR_BIT] <= p_or_r;
            sample_flags_r[FLAG_T_DA_BIT] <= t_new_r;
            sample_flags_r[FLAG_P_DA_BIT] <= p_new_r;
        end
    end

    always_comb begin
        rdata_nxt = BYTE_ZERO;
        unique case (reg_addr)
            ADDR_QUEUE_CTRL:   rdata_nxt = {ctrl_mode_r, queue_watermark_level_r};
            ADDR_TRIM_LOW:     rdata_nxt = pressure_offset_trim_r[7:0];
            ADDR_TRIM_HIGH:    rdata_nxt = pressure_offset_trim_r[15:8];
            ADDR_FILL_STATE:   rdata_nxt = {queue_watermark_flag, queue_overwrite_flag_r,
                                            queue_fill_count_r};
            ADDR_SAMPLE_FLAGS: rdata_nxt = sample_flags_r;
            ADDR_PRESS_LOW:    rdata_nxt = sor_byte_sel(head_data, BYTE_LOW);
            ADDR_PRESS_MID:    rdata_nxt = p_lock_r ? p_shadow_r[7:0]
                                         : sor_byte_sel(head_data, BYTE_MID);
            ADDR_PRESS_HIGH:   rdata_nxt = p_lock_r ? p_shadow_r[15:8]
                                         : sor_byte_sel(head_data, BYTE_HIGH);
            ADDR_TEMP_LOW:     rdata_nxt = sor_byte_sel(PRESS_W'(temperature_result_r),
                                                        BYTE_LOW);
            ADDR_TEMP_HIGH:    rdata_nxt = t_lock_r ? t_shadow_r
                                         : sor_byte_sel(PRESS_W'(temperature_result_r),
                                                        BYTE_MID);
            default:           rdata_nxt = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata    <= BYTE_ZERO;
            reg_rvalid   <= 1'b0;
            filter_clear <= 1'b0;
        end else begin
            reg_rvalid   <= reg_rd;
            filter_clear <= reg_rd && reg_addr == ADDR_FILTER_CLEAR;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_clear_read;
        reg_rd && reg_addr == ADDR_FILTER_CLEAR;
    endsequence
    sequence s_clear_pulse;
        filter_clear ##1 !filter_clear;
    endsequence

    a_watermark_read: assert property (reg_rd && reg_addr == ADDR_FILL_STATE |=>
        reg_rdata[FILL_WMARK_BIT] ==
        ($past(queue_fill_count_r) >= FILL_W'($past(queue_watermark_level_r))))
        else $error("watermark flag does not match fill count");
    a_overrun_full: assert property (queue_overwrite_flag_r |-> full)
        else $error("overrun flag set while queue not full");
    a_fill_bound: assert property (queue_fill_count_r <= FILL_FULL)
        else $error("fill count beyond depth");
    a_overwrite_status: assert property (overwrite |=>
        queue_overwrite_flag_r && full && queue_watermark_flag)
        else $error("status after overwrite is wrong");
    a_temp_overrun: assert property (temp_valid && t_new_r |=> t_or_r)
        else $error("temperature overrun missed");
    a_press_overrun: assert property (push && p_new_r |=> p_or_r)
        else $error("pressure overrun missed");
    a_temp_ready: assert property (temp_valid |=> t_new_r ##0
        temperature_result_r == $past(temp_meas))
        else $error("temperature ready flag or value not set");
    a_press_ready: assert property (push |=> p_new_r)
        else $error("pressure ready flag not set");
    a_flags_refresh: assert property (!odr_tick |=> $stable(sample_flags_r))
        else $error("sample flags changed outside a rate tick");
    a_press_low_byte: assert property (rd_p_low |=>
        reg_rdata == $past(head_data[7:0]) && reg_rvalid)
        else $error("pressure low byte wrong");
    a_trim_subtract: assert property (press_valid && !differential_select
        && !autozero_select && !auto_reference_hold |->
        PRESS_W'(trimmed + {pressure_offset_trim_r, 8'h00}) == press_meas)
        else $error("offset trim not subtracted");
    a_temp_high_byte: assert property (rd_t_low ##2 rd_t_high |=>
        reg_rdata == $past(temperature_result_r[15:8], 3))
        else $error("temperature high byte not coherent");
    a_filter_clear: assert property (s_clear_read |=> s_clear_pulse)
        else $error("filter clear pulse missing");
    a_ready_clear: assert property (rd_p_high && !push |=> !p_new_r)
        else $error("pressure ready flag not cleared by read");
    a_pop_count: assert property (pop && !push |=>
        queue_fill_count_r == $past(queue_fill_count_r) - FILL_W'(1))
        else $error("read did not remove one sample");
    a_shadow_hold: assert property (p_lock_r && !rd_p_low |=> $stable(p_shadow_r))
        else $error("pressure bytes changed during a read");
endmodule : sor_output_regs

// *** testbench/sor_host.sv ***
`timescale 1ns/1ps
module sor_host (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    input  wire logic       filter_clear
);
    initial begin
        reg_addr  = 8'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr

    // Byte read; also reports the filter clear pulse seen with the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic fc);
        int n = 0;
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (reg_rvalid !== 1'b1 && n < 4);
        d  = reg_rdata;
        fc = filter_clear;
        if (reg_rvalid !== 1'b1) tb.abort();
    endtask : rd
endmodule : sor_host

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import sor_pkg::*;
    logic        clk, resetn, press_valid, temp_valid, odr_tick;
    logic [2:0]  mode_sel;
    logic [23:0] press_meas;
    logic [15:0] temp_meas;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic        reg_rd, reg_wr, reg_rvalid, press_ready, filter_clear, fc;
    int          fails = 0;
    int          compares = 0;

    sor_output_regs #(.DEPTH(32)) uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .press_valid(press_valid), .press_meas(press_meas),
        .press_ready(press_ready), .temp_valid(temp_valid), .temp_meas(temp_meas),
        .odr_tick(odr_tick), .differential_select(mode_sel[0]), .autozero_select(mode_sel[1]),
        .auto_reference_hold(mode_sel[2]), .filter_clear(filter_clear));
    sor_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .filter_clear(filter_clear));

    task automatic conclude();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic abort();
        fails++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        conclude();
    endtask : abort
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d, fc);
        chk(d, exp);
    endtask : rd_chk
    task automatic rd_press(input logic [23:0] e);
        for (int k = 0; k < 3; k++)
            rd_chk(8'(ADDR_PRESS_LOW + k), e[8*k +: 8]);
    endtask : rd_press
    // Offered until taken; the line shows junk once released
    task automatic push(input logic [23:0] v);
        int n = 0;
        @(posedge clk);
        press_valid <= 1'b1;
        press_meas  <= v;
        do begin
            @(negedge clk);
            n++;
        end while (press_ready !== 1'b1 && n < 8);
        if (press_ready !== 1'b1) abort();
        @(posedge clk);
        press_valid <= 1'b0;
        press_meas  <= ~v;
        repeat (4) @(posedge clk);
    endtask : push
    task automatic pulse(input logic is_temp, input logic [15:0] v);
        @(posedge clk);
        temp_valid <= is_temp;
        odr_tick   <= !is_temp;
        temp_meas  <= v;
        @(posedge clk);
        temp_valid <= 1'b0;
        odr_tick   <= 1'b0;
    endtask : pulse

    task automatic t_reset();
        rd_chk(ADDR_FILL_STATE, 8'h80);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h00);
        rd_chk(ADDR_FILTER_CLEAR, 8'h00);
        chk({7'h00, fc}, 8'h01);
        rd_chk(8'h50, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_press();
        u_host.wr(ADDR_TRIM_LOW, 8'h34);
        u_host.wr(ADDR_TRIM_HIGH, 8'h12);
        push(24'h500000);
        rd_chk(ADDR_FILL_STATE, 8'h81);
        rd_press(24'h500000 - 24'h123400);
        rd_chk(ADDR_FILL_STATE, 8'h80);
        // Any one of the three mode inputs turns the trim off
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mode_sel <= 3'(1 << m);
            push(24'h800001 + 24'(m));
            rd_press(24'h800001 + 24'(m));
        end
        @(posedge clk);
        mode_sel <= 3'h0;
        $display("test pressure done");
    endtask : t_press
    task automatic t_temp();
        pulse(1'b0, 16'h0000);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h00);
        pulse(1'b1, 16'hbeef);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h00);
        pulse(1'b0, 16'h0000);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h02);
        pulse(1'b1, 16'h8001);
        pulse(1'b0, 16'h0000);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h22);
        rd_chk(ADDR_TEMP_LOW, 8'h01);
        rd_chk(ADDR_TEMP_HIGH, 8'h80);
        rd_chk(ADDR_TEMP_LOW, 8'h01);
        pulse(1'b1, 16'h1234);
        rd_chk(ADDR_TEMP_HIGH, 8'h80);
        pulse(1'b0, 16'h0000);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h00);
        $display("test temperature done");
    endtask : t_temp
    task automatic t_queue();
        u_host.wr(ADDR_QUEUE_CTRL, 8'h45);
        rd_chk(ADDR_QUEUE_CTRL, 8'h45);
        for (int i = 1; i <= 33; i++) begin
            push(24'(i));
            if (i == 4)
                rd_chk(ADDR_FILL_STATE, 8'h04);
            if (i == 5)
                rd_chk(ADDR_FILL_STATE, 8'h85);
        end
        rd_chk(ADDR_FILL_STATE, 8'he0);
        pulse(1'b0, 16'h0000);
        rd_chk(ADDR_SAMPLE_FLAGS, 8'h11);
        rd_press(24'h000002 - 24'h123400);
        rd_chk(ADDR_FILL_STATE, 8'h9f);
        $display("test queue done");
    endtask : t_queue

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        resetn      = 1'b0;
        press_valid = 1'b0;
        press_meas  = 24'h000000;
        temp_valid  = 1'b0;
        temp_meas   = 16'h0000;
        odr_tick    = 1'b0;
        mode_sel    = 3'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_press();
        t_temp();
        t_queue();
        conclude();
    end
endmodule : tb
